// [design/lfc_coeff_bank.sv]
// Left-channel effects and de-emphasis coefficient bank, Wishbone slave
//
// Operation
// (R1) Bank sits in page 1, indices 11-22
// (R2) Coefficient is high byte then low byte
// (R3) Coefficients are read as signed two's complement
// (R4) Numerator five low byte resets to 0x5d
// (R5) Denominator one resets to 0x7d, 0x83
// (R6) Denominator two resets to 0x84, 0xee
// (R7) Denominator four resets to 0x7d, 0x83
// (R8) Denominator five resets to 0x84, 0xee
// (R9) De-emphasis numerator zero high resets 0x39
// (R10) Numerator five high, index 11, resets 0x67
// (R11) De-emphasis numerator zero low, index 22, 0x55
// (R12) Assembled coefficients feed the filter datapath
`timescale 1ns/1ps
`default_nettype none

module lfc_coeff_bank #(
  parameter int BANK_SIZE = lfc_pkg::BANK_SIZE
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [lfc_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [lfc_pkg::WB_SEL_W-1:0] wb_sel_i,
  input wire logic [lfc_pkg::WB_DAT_W-1:0] wb_dat_i,
  output logic [lfc_pkg::WB_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [lfc_pkg::REG_W-1:0] pageSelect,
  output lfc_pkg::lfc_coeff_s coeffs
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic busRequest;
  logic writeCommit;
  logic readCapture;
  logic [lfc_pkg::INDEX_W-1:0] wordIndex;
  logic coeffPageOpen;
  logic bankHit;
  logic pageHit;
  logic statusHit;
  logic [lfc_pkg::INDEX_W-1:0] slotWide;
  logic [lfc_pkg::SLOT_W-1:0] bankSlot;
  logic [lfc_pkg::REG_W-1:0] writeByte;
  logic [BANK_SIZE-1:0] bankWrite;
  logic [lfc_pkg::REG_W-1:0] bankValue [BANK_SIZE];
  logic [lfc_pkg::COEFF_COUNT-1:0] modified;
  logic [lfc_pkg::COEFF_COUNT-1:0] modifiedSet;
  logic [lfc_pkg::COEFF_COUNT-1:0] modifiedClear;
  logic [lfc_pkg::REG_W-1:0] readByte;
  logic [lfc_pkg::REG_W-1:0] bankReadByte;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------

  // A request is live while the master holds cyc and stb
  assign busRequest = wb_cyc_i & wb_stb_i;

  // Writes land on the ack edge, the one edge the master commits on
  assign writeCommit = busRequest & wb_we_i & wb_ack_o & wb_sel_i[0];

  // Read data is caught one edge early so it stands beside ack
  assign readCapture = busRequest & ~wb_we_i & ~wb_ack_o;

  // Ack one cycle after the request, dropped in the following cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= busRequest & ~wb_ack_o;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  // Byte lanes 1 to 3 carry nothing; the word index picks the register
  assign wordIndex = wb_adr_i[lfc_pkg::WB_ADR_W-1:2];
  assign writeByte = wb_dat_i[lfc_pkg::REG_W-1:0];

  // The bank answers only while page 1 is selected
  assign coeffPageOpen = (pageSelect == lfc_pkg::COEFF_PAGE); // see R1

  // Bank window covers the paired bytes either side of 12-21
  assign bankHit = coeffPageOpen &&
                   (wordIndex >= lfc_pkg::IDX_LEFT_FX_NUM5_HIGH) &&
                   (wordIndex <= lfc_pkg::IDX_LEFT_DEEMPH_NUM0_LOW); // see R1

  // Page select and status stay reachable from any page
  assign pageHit = (wordIndex == lfc_pkg::IDX_PAGE_SELECT);
  assign statusHit = (wordIndex == lfc_pkg::IDX_BANK_STATUS);

  // Slot number inside the bank, narrowed on purpose
  assign slotWide = wordIndex - lfc_pkg::IDX_LEFT_FX_NUM5_HIGH;
  assign bankSlot = slotWide[lfc_pkg::SLOT_W-1:0];

  // ----------------------------------------------------------------
  // Page select
  // ----------------------------------------------------------------

  // Software flips pages here; page 0 holds nothing of this bank
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pageSelect <= lfc_pkg::RST_PAGE_SELECT;
    end else if (writeCommit && pageHit) begin
      pageSelect <= writeByte;
    end
  end

  // ----------------------------------------------------------------
  // Write strobes for the coefficient cells
  // ----------------------------------------------------------------

  // One strobe per cell, only for a committed write inside the bank
  always_comb begin
    bankWrite = '0;
    if (writeCommit && bankHit) begin
      bankWrite[bankSlot] = 1'b1; // see R2
    end
  end

  // ----------------------------------------------------------------
  // Coefficient storage cells
  // ----------------------------------------------------------------

  // Each cell takes its reset byte from the package table by slot
  for (genvar i = 0; i < BANK_SIZE; i++) begin : g_cell
    lfc_byte_reg #(
      .RESET_VALUE(lfc_pkg::BANK_RESET[i]) // see R4 R5 R6 R7 R8 R9 R10 R11
    ) u_cell (
      .clk(clk),
      .resetn(resetn),
      .writeEnable(bankWrite[i]),
      .writeData(writeByte),
      .value(bankValue[i])
    );
  end

  // ----------------------------------------------------------------
  // Coefficient assembly towards the filter
  // ----------------------------------------------------------------

  // Upper byte on top, lower byte below; each cell takes its own write at once,
  // so the filter may see a half-updated value between the two
  // byte writes, a hazard software avoids by muting first.
  always_comb begin
    coeffs.fxNumeratorFive = $signed({bankValue[0], bankValue[1]}); // see R2 R3 R12
    coeffs.fxDenominatorOne = $signed({bankValue[2], bankValue[3]}); // see R3 R12
    coeffs.fxDenominatorTwo = $signed({bankValue[4], bankValue[5]}); // see R3 R12
    coeffs.fxDenominatorFour = $signed({bankValue[6], bankValue[7]}); // see R3 R12
    coeffs.fxDenominatorFive = $signed({bankValue[8], bankValue[9]}); // see R3 R12
    coeffs.deemphNumeratorZero = $signed({bankValue[10], bankValue[11]}); // see R3 R12
  end

  // ----------------------------------------------------------------
  // Modified-since-reset flags
  // ----------------------------------------------------------------

  // A write to either byte marks that coefficient as changed
  always_comb begin
    modifiedSet = '0;
    for (int k = 0; k < BANK_SIZE; k++) begin
      if (bankWrite[k]) begin
        modifiedSet[k / 2] = 1'b1;
      end
    end
  end

  // Ones written to the status register clear the matching flags
  assign modifiedClear = (writeCommit && statusHit) ?
                         writeByte[lfc_pkg::COEFF_COUNT-1:0] : '0;

  // Set wins over clear so a racing write is never lost
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      modified <= lfc_pkg::RST_BANK_STATUS;
    end else begin
      modified <= (modified & ~modifiedClear) | modifiedSet;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // Bank byte by slot; slots past the bank never reach here
  always_comb begin
    bankReadByte = '0;
    for (int k = 0; k < BANK_SIZE; k++) begin
      if (bankSlot == k[lfc_pkg::SLOT_W-1:0]) begin
        bankReadByte = bankValue[k]; // see R2
      end
    end
  end

  // Unmapped addresses and the bank on a closed page read as zero
  always_comb begin
    readByte = '0;
    if (pageHit) begin
      readByte = pageSelect;
    end else if (statusHit) begin
      readByte = {{(lfc_pkg::REG_W - lfc_pkg::COEFF_COUNT){1'b0}}, modified};
    end else if (bankHit) begin
      readByte = bankReadByte;
    end
  end

  // Read data held from flops; upper lanes always zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wb_dat_o <= '0;
    end else if (readCapture) begin
      wb_dat_o <= {{(lfc_pkg::WB_DAT_W - lfc_pkg::REG_W){1'b0}}, readByte};
    end
  end

endmodule : lfc_coeff_bank

`default_nettype wire

// [design/lfc_pkg.sv]
// Package for the left-channel effects coefficient register bank
`default_nettype none
package lfc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int REG_W = 8;
  localparam int COEFF_W = 16;
  localparam int BANK_SIZE = 12;
  localparam int SLOT_W = 4;
  localparam int INDEX_W = 7;
  localparam int WB_ADR_W = 9;
  localparam int WB_DAT_W = 32;
  localparam int WB_SEL_W = 4;
  localparam int COEFF_COUNT = 6;

  // ----------------------------------------------------------------
  // Register indices; the bus byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [INDEX_W-1:0] IDX_PAGE_SELECT = 7'h00;
  localparam logic [INDEX_W-1:0] IDX_LEFT_FX_NUM5_HIGH = 7'h0b;
  localparam logic [INDEX_W-1:0] IDX_LEFT_FX_NUM5_LOW = 7'h0c;
  localparam logic [INDEX_W-1:0] IDX_LEFT_FX_DEN1_HIGH = 7'h0d;
  localparam logic [INDEX_W-1:0] IDX_LEFT_FX_DEN1_LOW = 7'h0e;
  localparam logic [INDEX_W-1:0] IDX_LEFT_FX_DEN2_HIGH = 7'h0f;
  localparam logic [INDEX_W-1:0] IDX_LEFT_FX_DEN2_LOW = 7'h10;
  localparam logic [INDEX_W-1:0] IDX_LEFT_FX_DEN4_HIGH = 7'h11;
  localparam logic [INDEX_W-1:0] IDX_LEFT_FX_DEN4_LOW = 7'h12;
  localparam logic [INDEX_W-1:0] IDX_LEFT_FX_DEN5_HIGH = 7'h13;
  localparam logic [INDEX_W-1:0] IDX_LEFT_FX_DEN5_LOW = 7'h14;
  localparam logic [INDEX_W-1:0] IDX_LEFT_DEEMPH_NUM0_HIGH = 7'h15;
  localparam logic [INDEX_W-1:0] IDX_LEFT_DEEMPH_NUM0_LOW = 7'h16;
  localparam logic [INDEX_W-1:0] IDX_BANK_STATUS = 7'h7f;

  // Page that holds the coefficient bank
  localparam logic [REG_W-1:0] COEFF_PAGE = 8'h01;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] RST_PAGE_SELECT = 8'h00;
  localparam logic [REG_W-1:0] RST_LEFT_FX_NUM5_HIGH = 8'h67;
  localparam logic [REG_W-1:0] RST_LEFT_FX_NUM5_LOW = 8'h5d;
  localparam logic [REG_W-1:0] RST_LEFT_FX_DEN1_HIGH = 8'h7d;
  localparam logic [REG_W-1:0] RST_LEFT_FX_DEN1_LOW = 8'h83;
  localparam logic [REG_W-1:0] RST_LEFT_FX_DEN2_HIGH = 8'h84;
  localparam logic [REG_W-1:0] RST_LEFT_FX_DEN2_LOW = 8'hee;
  localparam logic [REG_W-1:0] RST_LEFT_FX_DEN4_HIGH = 8'h7d;
  localparam logic [REG_W-1:0] RST_LEFT_FX_DEN4_LOW = 8'h83;
  localparam logic [REG_W-1:0] RST_LEFT_FX_DEN5_HIGH = 8'h84;
  localparam logic [REG_W-1:0] RST_LEFT_FX_DEN5_LOW = 8'hee;
  localparam logic [REG_W-1:0] RST_LEFT_DEEMPH_NUM0_HIGH = 8'h39;
  localparam logic [REG_W-1:0] RST_LEFT_DEEMPH_NUM0_LOW = 8'h55;
  localparam logic [COEFF_COUNT-1:0] RST_BANK_STATUS = 6'h00;

  // Reset values in slot order, slot = index - IDX_LEFT_FX_NUM5_HIGH
  localparam logic [REG_W-1:0] BANK_RESET [BANK_SIZE] = '{
    RST_LEFT_FX_NUM5_HIGH, RST_LEFT_FX_NUM5_LOW,
    RST_LEFT_FX_DEN1_HIGH, RST_LEFT_FX_DEN1_LOW,
    RST_LEFT_FX_DEN2_HIGH, RST_LEFT_FX_DEN2_LOW,
    RST_LEFT_FX_DEN4_HIGH, RST_LEFT_FX_DEN4_LOW,
    RST_LEFT_FX_DEN5_HIGH, RST_LEFT_FX_DEN5_LOW,
    RST_LEFT_DEEMPH_NUM0_HIGH, RST_LEFT_DEEMPH_NUM0_LOW
  };

  // ----------------------------------------------------------------
  // Coefficient carrier towards the filter datapath
  // ----------------------------------------------------------------
  typedef struct packed {
    logic signed [COEFF_W-1:0] fxNumeratorFive;
    logic signed [COEFF_W-1:0] fxDenominatorOne;
    logic signed [COEFF_W-1:0] fxDenominatorTwo;
    logic signed [COEFF_W-1:0] fxDenominatorFour;
    logic signed [COEFF_W-1:0] fxDenominatorFive;
    logic signed [COEFF_W-1:0] deemphNumeratorZero;
  } lfc_coeff_s;

endpackage : lfc_pkg

`default_nettype wire

// [design/lfc_byte_reg.sv]
// One byte-wide read/write coefficient storage cell
`timescale 1ns/1ps
`default_nettype none

module lfc_byte_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic writeEnable,
  input wire logic [7:0] writeData,
  output logic [7:0] value
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------

  // Loads its own constant under reset, else takes each write
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      value <= RESET_VALUE;
    end else if (writeEnable) begin
      value <= writeData;
    end
  end

endmodule : lfc_byte_reg

`default_nettype wire

// [dv/lfc_coeff_bank_properties.sv]
// Port-level assertions for the coefficient bank
`timescale 1ns/1ps
`default_nettype none
module lfc_coeff_bank_properties (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [8:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [7:0] pageSelect,
  input wire lfc_pkg::lfc_coeff_s coeffs
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic inBank;
  logic hit;
  // Access lands in the bank and the bank page is open
  assign inBank = wb_adr_i[8:2] >= 7'h0b && wb_adr_i[8:2] <= 7'h16;
  assign hit = wb_ack_o && pageSelect == 8'h01;
  chk_ack_follows: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  chk_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_read_upper: assert property (
    wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0) else $error("upper");
  chk_reset_den: assert property (
    $rose(resetn) |-> coeffs.fxDenominatorOne == 16'h7d83
      && coeffs.fxDenominatorTwo == 16'h84ee
      && coeffs.fxDenominatorFour == 16'h7d83
      && coeffs.fxDenominatorFive == 16'h84ee) else $error("den reset");
  chk_reset_num: assert property (
    $rose(resetn) |-> coeffs.fxNumeratorFive == 16'h675d
      && coeffs.deemphNumeratorZero == 16'h3955) else $error("num reset");
  chk_high_write: assert property (
    hit && wb_we_i && wb_sel_i[0] && wb_adr_i[8:2] == 7'h0d |=>
      coeffs.fxDenominatorOne[15:8] == $past(wb_dat_i[7:0]))
    else $error("high byte write");
  chk_low_read: assert property (
    hit && !wb_we_i && wb_adr_i[8:2] == 7'h14 |->
      wb_dat_o[7:0] == coeffs.fxDenominatorFive[7:0]) else $error("read");
  chk_page_hidden: assert property (
    wb_ack_o && !wb_we_i && pageSelect != 8'h01 && inBank |->
      wb_dat_o == 32'h0) else $error("bank visible off page");
  chk_write_dropped: assert property (
    wb_ack_o && wb_we_i && pageSelect != 8'h01 && inBank |=>
      $stable(coeffs)) else $error("write off page");
  // Main scenarios reached
  cover property (hit && wb_we_i && inBank);
  cover property (hit && !wb_we_i && inBank);
  cover property (wb_ack_o && pageSelect != 8'h01 && inBank);
endmodule : lfc_coeff_bank_properties

bind lfc_coeff_bank lfc_coeff_bank_properties u_lfc_coeff_bank_properties (
  .clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .pageSelect, .coeffs);
`default_nettype wire

// [dv/lfc_coeff_bank_tb_top.sv]
// Self-checking testbench for the coefficient bank
`timescale 1ns/1ps
`default_nettype none
module lfc_coeff_bank_tb_top;
  logic clk, resetn, wbCyc, wbStb, wbWe, wbAck;
  logic [8:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatW, wbDatR;
  logic [7:0] pageSelect;
  lfc_pkg::lfc_coeff_s coeffs;
  logic [7:0] shadow [12];
  int fails = 0;
  int checks_done = 0;
  lfc_coeff_bank u_lfc_coeff_bank (.clk(clk), .resetn(resetn),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
    .wb_ack_o(wbAck), .pageSelect(pageSelect), .coeffs(coeffs));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One classic cycle; waits for ack, bounded so a dead slave ends the run
  task automatic wb_xfer(input logic we, input logic [6:0] idx,
      input logic [7:0] d, input logic [3:0] sel, output logic [7:0] q);
    int n;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= {idx, 2'b00};
    wbSel <= sel;
    wbDatW <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      give_verdict();
    end else begin
      q = wbDatR[7:0];
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
    end
  endtask : wb_xfer
  // Coefficients as the filter should see them, slots high byte first
  function automatic logic [95:0] exp_coeffs();
    logic [95:0] e;
    e = '0;
    for (int i = 0; i < 12; i++)
      e = {e[87:0], shadow[i]};
    return e;
  endfunction : exp_coeffs
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_values();
    logic [7:0] q;
    wb_xfer(1'b1, 7'h00, 8'h01, 4'h1, q);
    @(negedge clk);
    check(96'(pageSelect), 96'(lfc_pkg::COEFF_PAGE));
    wb_xfer(1'b0, 7'h00, 8'h00, 4'h1, q);
    check(96'(q), 96'(lfc_pkg::COEFF_PAGE));
    for (int i = 0; i < 12; i++) begin
      wb_xfer(1'b0, 7'(7'h0b + i), 8'h00, 4'h1, q);
      check(96'(q), 96'(lfc_pkg::BANK_RESET[i]));
    end
    check(coeffs, exp_coeffs());
    check(96'(coeffs.fxDenominatorTwo < 0), 96'h1);
    $display("test_reset_values done");
  endtask : test_reset_values
  task automatic test_write_back();
    logic [7:0] q;
    for (int i = 0; i < 12; i++) begin
      shadow[i] = 8'h3c ^ 8'(i * 23);
      wb_xfer(1'b1, 7'(7'h0b + i), shadow[i], 4'h1, q);
      @(negedge clk);
      check(coeffs, exp_coeffs());
    end
    for (int i = 0; i < 12; i++) begin
      wb_xfer(1'b0, 7'(7'h0b + i), 8'h00, 4'h1, q);
      check(96'(q), 96'(shadow[i]));
    end
    wb_xfer(1'b1, 7'h0d, 8'h80, 4'h1, q);
    wb_xfer(1'b1, 7'h0e, 8'h00, 4'h1, q);
    @(negedge clk);
    check(96'(coeffs.fxDenominatorOne == 16'sh8000), 96'h1);
    wb_xfer(1'b1, 7'h0d, 8'h7f, 4'h1, q);
    wb_xfer(1'b1, 7'h0e, 8'hff, 4'h1, q);
    @(negedge clk);
    check(96'(coeffs.fxDenominatorOne == 16'sh7fff), 96'h1);
    shadow[2] = 8'h7f;
    shadow[3] = 8'hff;
    wb_xfer(1'b0, 7'h0a, 8'h00, 4'h1, q);
    check(96'(q), 96'h0);
    wb_xfer(1'b0, 7'h17, 8'h00, 4'h1, q);
    check(96'(q), 96'h0);
    $display("test_write_back done");
  endtask : test_write_back
  task automatic test_page_guard();
    logic [7:0] q;
    wb_xfer(1'b1, 7'h00, 8'h02, 4'h1, q);
    wb_xfer(1'b1, 7'h0e, 8'h5a, 4'h1, q);
    wb_xfer(1'b0, 7'h0e, 8'h00, 4'h1, q);
    check(96'(q), 96'h0);
    wb_xfer(1'b1, 7'h00, 8'h01, 4'h1, q);
    wb_xfer(1'b1, 7'h0e, 8'h5a, 4'h0, q);
    @(negedge clk);
    check(coeffs, exp_coeffs());
    $display("test_page_guard done");
  endtask : test_page_guard
  task automatic test_mid_reset();
    logic [7:0] q;
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    shadow = lfc_pkg::BANK_RESET;
    @(negedge clk);
    check(coeffs, exp_coeffs());
    check(96'(pageSelect), 96'(lfc_pkg::RST_PAGE_SELECT));
    // Status flags: clear after reset, set by a byte write, cleared by ones
    wb_xfer(1'b0, 7'h7f, 8'h00, 4'h1, q);
    check(96'(q), 96'(lfc_pkg::RST_BANK_STATUS));
    wb_xfer(1'b1, 7'h00, 8'h01, 4'h1, q);
    wb_xfer(1'b1, 7'h0e, 8'h5a, 4'h1, q);
    shadow[3] = 8'h5a;
    @(negedge clk);
    check(coeffs, exp_coeffs());
    wb_xfer(1'b0, 7'h7f, 8'h00, 4'h1, q);
    check(96'(q), 96'h02);
    wb_xfer(1'b1, 7'h7f, 8'h02, 4'h1, q);
    wb_xfer(1'b0, 7'h7f, 8'h00, 4'h1, q);
    check(96'(q), 96'h00);
    $display("test_mid_reset done");
  endtask : test_mid_reset
  // Main sequence: two-cycle reset, then every scenario
  initial begin
    {resetn, wbCyc, wbStb, wbWe} = 4'h0;
    wbAdr = 9'h000;
    wbSel = 4'h0;
    wbDatW = 32'h0;
    shadow = lfc_pkg::BANK_RESET;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    test_reset_values();
    test_write_back();
    test_page_guard();
    test_mid_reset();
    give_verdict();
  end
endmodule : lfc_coeff_bank_tb_top
`default_nettype wire
